// File: slm_pkg.sv
// Purpose: constants and carriers for the lane mapper and power block
// Assumes: APB register access, one 200 MHz clock
// Notes:   register offsets are byte addresses
//
// Behaviour
// - 8-bit 64b66b: one sample per octet per lane
// - 9-bit 8b10b: zero pad, four samples per lane
// - 9-bit 64b66b quad: lane pair per channel
// - 9-bit 64b66b dual: lane k takes k, k+4
// - sync header carries CRC-12 or FEC only
// - redundancy only with four or fewer lanes
// - alternate select picks lanes 3..0 or 7..4
// - only one lane group driven at once below eight lanes
// - power-down pin disables all lane drivers
// - operating-state field also powers everything down
// - after power-down, link restarts, stale data flushed
// - settings survive power-down unchanged
// - channel pairs power down independently
// - test modes replace samples with known patterns
// - test select field; lane count follows lane count setting
package slm_pkg;

  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [7:0]  ADDR_CTRL   = 8'h00;  // control word
  localparam logic [7:0]  ADDR_STATUS = 8'h04;  // read-only state
  localparam int          POS_FMT     = 0;      // lane format, 2 bits
  localparam int          POS_LCNT    = 2;      // lane count, 2 bits
  localparam int          POS_ALT     = 4;      // alternate group
  localparam int          POS_SH      = 5;      // sync header kind
  localparam int          POS_OPPD    = 6;      // operating-state power-down
  localparam int          POS_TEST    = 8;      // test pattern, 2 bits
  localparam int          POS_CHEN    = 12;     // channel pair enables, 2 bits
  localparam logic [1:0]  RST_CHEN    = 2'h3;   // both pairs on after reset

  // ****************************************************
  // encodings and sizes
  // ****************************************************
  localparam logic [1:0]  FMT_8B_64   = 2'h0;   // 8-bit, 64b66b, dual/single
  localparam logic [1:0]  FMT_9B_8B   = 2'h1;   // 9-bit, 8b10b, dual/single
  localparam logic [1:0]  FMT_9B_64Q  = 2'h2;   // 9-bit, 64b66b, 8/4/2 lanes
  localparam logic [1:0]  FMT_9B_64D  = 2'h3;   // 9-bit, 64b66b, dual/single
  localparam logic [1:0]  LCNT_8      = 2'h0;   // eight lanes
  localparam logic [1:0]  LCNT_4      = 2'h1;   // four lanes
  localparam logic [1:0]  TEST_OFF    = 2'h0;   // converter data
  localparam logic [1:0]  TEST_RAMP   = 2'h1;   // incrementing octet
  localparam logic [1:0]  TEST_CLOCK  = 2'h2;   // eight ones, eight zeros
  localparam logic [2:0]  OCT_8B_64   = 3'h1;   // octets per frame per lane
  localparam logic [2:0]  OCT_9B_8B   = 3'h5;
  localparam logic [2:0]  OCT_9B_64   = 3'h3;
  localparam logic [7:0]  CLK_ONES    = 8'hFF;  // clock pattern high half
  localparam int          NCH         = 4;      // channels A..D
  localparam int          NSMP        = 16;     // samples per channel per frame
  localparam int          NLANE       = 8;
  localparam int          FLUSH_NS    = 320;    // pipeline flush after wake
  localparam int          CLK_PS      = 5000;   // 200 MHz period
  localparam logic [7:0]  FLUSH_CYC   = 8'((FLUSH_NS * 1000 + CLK_PS - 1) / CLK_PS);

  // ****************************************************
  // carriers
  // ****************************************************
  typedef logic [NCH-1:0][NSMP-1:0][8:0] slm_frame_type;   // samples, index 0 oldest

  typedef struct packed {
    logic [1:0] fmt;     // lane_format_select
    logic [1:0] lcnt;    // lane count
    logic       alt;     // alternate_group_select
    logic       sh_fec;  // 0 crc-12, 1 fec
    logic       op_pd;   // operating-state power-down
    logic [1:0] test;    // test_pattern_select
    logic [1:0] chen;    // channel_pair_power_enable
  } slm_ctrl_type;

endpackage

// File: slm_lane_map.sv
// Purpose: pack converter frames onto eight serial lanes, handle power and test modes
// Assumes: APB slave, lanes take one octet per lane per accepted beat
// Notes:   a two-entry frame buffer absorbs stalls from the lane side
`timescale 1ns/1ps

module slm_lane_map
(
  // clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic                               pready,
  output logic [31:0]                        prdata,
  output logic                               pslverr,
  // converter frames
  input  wire logic                          in_valid,
  input  wire slm_pkg::slm_frame_type        in_frame,
  output logic                               in_ready,
  // lanes
  input  wire logic                          lane_ready,
  output logic [7:0][7:0]                    lane_octet,
  output logic                               lane_valid,
  output logic [7:0]                         lane_drive_en,
  output logic                               sync_header_fec,
  // pins
  input  wire logic                          power_down_pin
);

  // ****************************************************
  // state
  // ****************************************************
  typedef struct packed {
    slm_pkg::slm_ctrl_type                ctrl;       // software settings
    slm_pkg::slm_frame_type               buf0;       // head entry
    slm_pkg::slm_frame_type               buf1;       // second entry
    logic [1:0]                           cnt;        // buffer fill
    logic [7:0][39:0]                     sh;         // per lane shifter
    logic [2:0]                           left;       // octets still to send
    logic [7:0]                           flush;      // flush countdown
    logic                                 pd;         // powered down last cycle
    logic [7:0]                           ramp;       // ramp octet
    logic                                 clk_ph;     // clock pattern half
    logic                                 in_ready;
    logic [7:0][7:0]                      oct;
    logic                                 valid;
    logic [7:0]                           drv;
    logic                                 pready;
    logic [31:0]                          prdata;
    logic                                 pslverr;
  } slm_state_type;

  slm_state_type s_q;                                 // registered state
  slm_state_type s_d;                                 // next state

  // ****************************************************
  // lane builder
  // ****************************************************
  // first octet out is bits 39:32; sample msb leads, pad follows
  function automatic logic [39:0] slm_build(logic [1:0] fmt, int l, slm_pkg::slm_frame_type f);
    logic [39:0] r;
    int          ch;
    int          i;
    r  = '0;
    ch = l / 4;
    i  = l % 4;
    case (fmt)
      slm_pkg::FMT_8B_64:
        r = {f[ch][i][8:1], 32'h0000_0000};
      slm_pkg::FMT_9B_8B:
        r = {f[ch][i], 1'b0, f[ch][i+4], 1'b0, f[ch][i+8], 1'b0, f[ch][i+12], 1'b0};
      slm_pkg::FMT_9B_64Q:
        r = {f[l/2][l%2], 3'h0, f[l/2][l%2+2], 3'h0, 16'h0000};
      slm_pkg::FMT_9B_64D:
        r = {f[ch][i], 3'h0, f[ch][i+4], 3'h0, 16'h0000};
      default:
        r = '0;
    endcase
    return r;
  endfunction

  // ****************************************************
  // next state
  // ****************************************************
  logic                   pd_now;     // either power-down source
  logic                   adv;        // lane side can take a beat
  logic                   pop;        // head entry leaves buffer
  logic                   push;       // new frame enters
  logic                   redund;     // data on alternate group
  logic [7:0]             mask;       // logical lanes in use
  logic [2:0]             olen;       // octets per frame
  logic [7:0][39:0]       built;      // logical lane frames
  slm_pkg::slm_frame_type hf;         // head with disabled pairs zeroed
  logic [1:0]             cnt_mid;    // fill after pop

  always_comb
  begin
    s_d     = s_q;
    pop     = 1'b0;
    hf      = s_q.buf0;
    built   = '0;
    pd_now  = power_down_pin | s_q.ctrl.op_pd;
    push    = in_valid & s_q.in_ready;
    adv     = ~s_q.valid | lane_ready;
    // disabled pair feeds zeros; powers down without touching other pair
    for (int c = 0; c < slm_pkg::NCH; c++)
    begin
      if (!s_q.ctrl.chen[c/2])
      begin
        hf[c] = '0;
      end
    end
    // lane count follows the lcnt setting even in test mode
    case (s_q.ctrl.lcnt)
      slm_pkg::LCNT_8: mask = 8'hFF;
      slm_pkg::LCNT_4: mask = 8'h0F;
      default:         mask = 8'h03;
    endcase
    // redundancy refused when eight lanes are in use
    redund = s_q.ctrl.alt & (s_q.ctrl.lcnt != slm_pkg::LCNT_8);
    case (s_q.ctrl.fmt)
      slm_pkg::FMT_8B_64: olen = slm_pkg::OCT_8B_64;
      slm_pkg::FMT_9B_8B: olen = slm_pkg::OCT_9B_8B;
      default:            olen = slm_pkg::OCT_9B_64;
    endcase
    for (int p = 0; p < slm_pkg::NLANE; p++)
    begin
      // alternate group is a copy of logical lanes 3..0 on 7..4
      built[p] = slm_build(s_q.ctrl.fmt, redund ? (p % 4) : p, hf);
    end

    // apb: answer ready in the cycle after setup
    s_d.pready  = psel & ~penable;
    s_d.pslverr = 1'b0;
    s_d.prdata  = 32'h0000_0000;
    if (psel && !penable)
    begin
      if (paddr == slm_pkg::ADDR_CTRL)
      begin
        s_d.prdata[slm_pkg::POS_FMT +: 2]  = s_q.ctrl.fmt;
        s_d.prdata[slm_pkg::POS_LCNT +: 2] = s_q.ctrl.lcnt;
        s_d.prdata[slm_pkg::POS_ALT]       = s_q.ctrl.alt;
        s_d.prdata[slm_pkg::POS_SH]        = s_q.ctrl.sh_fec;
        s_d.prdata[slm_pkg::POS_OPPD]      = s_q.ctrl.op_pd;
        s_d.prdata[slm_pkg::POS_TEST +: 2] = s_q.ctrl.test;
        s_d.prdata[slm_pkg::POS_CHEN +: 2] = s_q.ctrl.chen;
      end
      else if (paddr == slm_pkg::ADDR_STATUS)
      begin
        s_d.prdata[0] = s_q.pd;
        s_d.prdata[1] = (s_q.flush != 8'h00);
        s_d.prdata[2] = redund;
        s_d.prdata[3] = (s_q.cnt == 2'h2);
      end
      else
      begin
        s_d.pslverr = 1'b1;                     // unmapped address
      end
    end
    // write lands only at the completing edge; power-down never resets it
    if (psel && penable && s_q.pready && pwrite && paddr == slm_pkg::ADDR_CTRL)
    begin
      s_d.ctrl.fmt    = pwdata[slm_pkg::POS_FMT +: 2];
      s_d.ctrl.lcnt   = pwdata[slm_pkg::POS_LCNT +: 2];
      s_d.ctrl.alt    = pwdata[slm_pkg::POS_ALT];
      s_d.ctrl.sh_fec = pwdata[slm_pkg::POS_SH];
      s_d.ctrl.op_pd  = pwdata[slm_pkg::POS_OPPD];
      s_d.ctrl.test   = pwdata[slm_pkg::POS_TEST +: 2];
      s_d.ctrl.chen   = pwdata[slm_pkg::POS_CHEN +: 2];
    end

    // wake-up starts a flush so stale pipeline words never reach the lanes
    s_d.pd = pd_now;
    if (s_q.pd && !pd_now)
    begin
      s_d.flush = slm_pkg::FLUSH_CYC;
    end
    else if (s_q.flush != 8'h00)
    begin
      s_d.flush = s_q.flush - 8'h01;
    end

    // serializer
    if (pd_now)
    begin
      s_d.valid = 1'b0;
      s_d.left  = 3'h0;
    end
    else if (adv)
    begin
      s_d.valid = 1'b0;
      if (s_q.ctrl.test != slm_pkg::TEST_OFF)
      begin
        // patterns replace samples; frames are drained and dropped
        pop        = (s_q.cnt != 2'h0);
        s_d.valid  = 1'b1;
        s_d.left   = 3'h0;
        s_d.ramp   = s_q.ramp + 8'h01;
        s_d.clk_ph = ~s_q.clk_ph;
        for (int p = 0; p < slm_pkg::NLANE; p++)
        begin
          if (s_q.ctrl.test == slm_pkg::TEST_RAMP)
            s_d.oct[p] = s_q.ramp;
          else if (s_q.ctrl.test == slm_pkg::TEST_CLOCK)
            s_d.oct[p] = s_q.clk_ph ? 8'h00 : slm_pkg::CLK_ONES;
          else
            s_d.oct[p] = 8'h00;                 // reserved selection sends zeros
        end
      end
      else if (s_q.left != 3'h0)
      begin
        s_d.valid = 1'b1;
        s_d.left  = s_q.left - 3'h1;
        for (int p = 0; p < slm_pkg::NLANE; p++)
        begin
          s_d.oct[p] = s_q.sh[p][39:32];
          s_d.sh[p]  = {s_q.sh[p][31:0], 8'h00};
        end
      end
      else if (s_q.cnt != 2'h0)
      begin
        pop = 1'b1;
        if (s_q.flush == 8'h00)
        begin
          s_d.valid = 1'b1;
          s_d.left  = olen - 3'h1;
          for (int p = 0; p < slm_pkg::NLANE; p++)
          begin
            s_d.oct[p] = built[p][39:32];
            s_d.sh[p]  = {built[p][31:0], 8'h00};
          end
        end
      end
    end

    // drivers: one group only below eight lanes, nothing while powered down
    if (pd_now)
      s_d.drv = 8'h00;
    else if (redund)
      s_d.drv = {mask[3:0], 4'h0};
    else
      s_d.drv = mask;

    // two-entry buffer
    cnt_mid = s_q.cnt - {1'b0, pop};
    if (pop)
    begin
      s_d.buf0 = s_q.buf1;
    end
    if (push && !pd_now)
    begin
      if (cnt_mid == 2'h0)
        s_d.buf0 = in_frame;
      else
        s_d.buf1 = in_frame;
      cnt_mid = cnt_mid + 2'h1;
    end
    s_d.cnt      = pd_now ? 2'h0 : cnt_mid;
    s_d.in_ready = ~pd_now & (cnt_mid != 2'h2);
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_q           <= '0;
      s_q.ctrl.chen <= slm_pkg::RST_CHEN;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign pready          = s_q.pready;
  assign prdata          = s_q.prdata;
  assign pslverr         = s_q.pslverr;
  assign in_ready        = s_q.in_ready;
  assign lane_octet      = s_q.oct;
  assign lane_valid      = s_q.valid;
  assign lane_drive_en   = s_q.drv;
  assign sync_header_fec = s_q.ctrl.sh_fec;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_pin_off;
    power_down_pin |=> (lane_drive_en == 8'h00) && !lane_valid;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("drivers on during pin power-down");

  property p_reg_off;
    s_q.ctrl.op_pd |=> lane_drive_en == 8'h00;
  endproperty
  a_reg_off: assert property (p_reg_off) else $error("drivers on in register power-down");

  // enables are one cycle behind the lane count, so judge them the cycle after
  property p_one_group;
    (s_q.ctrl.lcnt != slm_pkg::LCNT_8) |=> !((|lane_drive_en[7:4]) && (|lane_drive_en[3:0]));
  endproperty
  a_one_group: assert property (p_one_group) else $error("both lane groups driven");

  property p_alt_group;
    (s_q.ctrl.alt && s_q.ctrl.lcnt == slm_pkg::LCNT_4 && !pd_now) [*2] |-> lane_drive_en == 8'hF0;
  endproperty
  a_alt_group: assert property (p_alt_group) else $error("alternate group not selected");

  property p_no_redund8;
    (s_q.ctrl.lcnt == slm_pkg::LCNT_8 && !pd_now) [*2] |-> lane_drive_en == 8'hFF;
  endproperty
  a_no_redund8: assert property (p_no_redund8) else $error("eight lane mode altered");

  property p_keep_cfg;
    (pd_now && !(psel && pwrite)) |=> $stable(s_q.ctrl);
  endproperty
  a_keep_cfg: assert property (p_keep_cfg) else $error("settings lost in power-down");

  property p_flush;
    (s_q.pd && !pd_now) |=> (s_q.flush == slm_pkg::FLUSH_CYC) ##1 !lane_valid [*3];
  endproperty
  a_flush: assert property (p_flush) else $error("no flush after wake");

  property p_test_run;
    (s_q.ctrl.test == slm_pkg::TEST_RAMP && !pd_now && lane_ready) [*2] |-> lane_valid
      ##1 (lane_octet[0] == $past(lane_octet[0]) + 8'h01);
  endproperty
  a_test_run: assert property (p_test_run) else $error("ramp pattern broken");

endmodule

// File: slm_lane_sink.sv
// Purpose: lane receiver model that collects every beat taken from the lanes
// Assumes: one beat per edge with lane_valid and lane_ready both high
// Notes:   slow mode drops ready every other cycle so stalls land mid-frame
`timescale 1ns/1ps

module slm_lane_sink
(
  // clock and reset
  input  wire logic            pclk,
  input  wire logic            presetn,
  // lanes
  input  wire logic [7:0][7:0] lane_octet,
  input  wire logic            lane_valid,
  output logic                 lane_ready,
  // pacing from the bench
  input  wire logic            stall,
  input  wire logic            slow
);
  logic [63:0] beats[$];  // captured beats, oldest first
  logic        tick_q;    // slow-mode phase

  // ****************************************************
  // pacing and capture
  // ****************************************************
  // the bench clears the queue after a wake, so stale beats are never judged
  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      tick_q <= 1'b0;
      beats.delete();
    end
    else
    begin
      tick_q <= ~tick_q;
      if (lane_valid && lane_ready)
        beats.push_back(lane_octet);
    end

  // ready is a level; a stall holds the current beat on the lanes
  assign lane_ready = !stall && !(slow && tick_q);
endmodule

// File: slm_lane_map_tb_top.sv
// Purpose: self-checking bench for the lane mapper and power block
// Assumes: zero-wait apb slave, two-entry frame buffer, 64-cycle flush after wake
// Notes:   expected octets are rebuilt here from sample index and slot width
`timescale 1ns/1ps

module slm_lane_map_tb_top;
  logic                   pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]             paddr;
  logic [31:0]            pwdata, prdata, rd, ctrl_last;
  logic                   in_valid, in_ready, lane_ready, lane_valid, sync_header_fec;
  logic                   power_down_pin, er, stall, slow, took;
  slm_pkg::slm_frame_type in_frame;
  logic [7:0][7:0]        lane_octet;
  logic [7:0]             lane_drive_en;
  int                     num_errors, n_checks, acc;

  slm_lane_map slm_lane_map_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .in_valid(in_valid), .in_frame(in_frame), .in_ready(in_ready),
    .lane_ready(lane_ready), .lane_octet(lane_octet), .lane_valid(lane_valid),
    .lane_drive_en(lane_drive_en), .sync_header_fec(sync_header_fec),
    .power_down_pin(power_down_pin));
  slm_lane_sink slm_lane_sink_i (.pclk(pclk), .presetn(presetn), .lane_octet(lane_octet),
    .lane_valid(lane_valid), .lane_ready(lane_ready), .stall(stall), .slow(slow));

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // ****************************************************
  // checking and closing
  // ****************************************************
  task automatic wrap_up;
    if (num_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic hang;
    num_errors++;
    $display("mismatch at %0t: wait ran out", $time);
    wrap_up();
  endtask

  // ****************************************************
  // apb master: hold request until pready seen high
  // ****************************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
      hang();
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [31:0] cw(input logic [1:0] f, lc, input logic alt, fec, pd,
                                     input logic [1:0] t, ce);
    return (32'(f) << slm_pkg::POS_FMT) | (32'(lc) << slm_pkg::POS_LCNT) | (32'(alt) << slm_pkg::POS_ALT)
         | (32'(fec) << slm_pkg::POS_SH) | (32'(pd) << slm_pkg::POS_OPPD)
         | (32'(t) << slm_pkg::POS_TEST) | (32'(ce) << slm_pkg::POS_CHEN);
  endfunction

  task automatic cfg(input logic [31:0] w);
    ctrl_last = w;
    apb(1'b1, slm_pkg::ADDR_CTRL, w);
  endtask

  // ****************************************************
  // frames and expected lane octets
  // ****************************************************
  function automatic slm_pkg::slm_frame_type mk(input int fr);
    slm_pkg::slm_frame_type v;
    for (int c = 0; c < slm_pkg::NCH; c++)
      for (int s = 0; s < slm_pkg::NSMP; s++)
        v[c][s] = 9'((c * 16 + s) * 29 + 7 + fr * 3);
    return v;
  endfunction

  // slots are packed oldest first, sample msb first, pad zeros after
  function automatic logic [7:0] exp_oct(input logic [1:0] f, input int k, b, fr);
    slm_pkg::slm_frame_type v;
    logic [47:0]            w;
    int                     ch, st, cnt, sw, ix;
    v   = mk(fr);
    w   = '0;
    st  = (f == slm_pkg::FMT_9B_64Q) ? 2 : 4;
    ch  = k / st;
    cnt = (f == slm_pkg::FMT_9B_8B) ? 4 : (f == slm_pkg::FMT_8B_64) ? 1 : 2;
    sw  = (f == slm_pkg::FMT_9B_8B) ? 10 : (f == slm_pkg::FMT_8B_64) ? 8 : 12;
    for (int i = 0; i < cnt; i++)
    begin
      ix = k % st + st * i;
      if (f == slm_pkg::FMT_8B_64)
        w = 48'(v[ch][ix][8:1]);
      else
        w = (w << sw) | (48'(v[ch][ix]) << (sw - 9));
    end
    return w[(cnt * sw / 8 - 1 - b) * 8 +: 8];
  endfunction

  task automatic send(input int fr, input int tries, output logic ok);
    int i;
    ok = 1'b0;
    @(posedge pclk);
    in_frame <= mk(fr);
    in_valid <= 1'b1;
    for (i = 0; i < tries; i++)
    begin
      @(posedge pclk);
      if (in_ready === 1'b1)
        break;
    end
    ok = (i < tries);
    in_valid <= 1'b0;
  endtask

  // compare cnt frames from fr0 on, lanes outside mask expected zero
  task automatic cmp(input logic [1:0] f, input int fr0, cnt, input logic [7:0] mask);
    int n, i;
    logic [63:0] bt;
    n = (f == slm_pkg::FMT_8B_64) ? 1 : (f == slm_pkg::FMT_9B_8B) ? 5 : 3;
    for (i = 0; i < 600 && slm_lane_sink_i.beats.size() < n * cnt; i++)
      @(posedge pclk);
    if (i == 600)
      hang();
    for (int j = 0; j < cnt * n; j++)
    begin
      bt = slm_lane_sink_i.beats[j];
      for (int k = 0; k < 8; k++)
        chk(bt[k * 8 +: 8], mask[k] ? exp_oct(f, k, j % n, fr0 + j / n) : 8'h00);
    end
    slm_lane_sink_i.beats.delete();
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial
  begin
    {pclk, presetn, psel, penable, pwrite, in_valid, power_down_pin, stall, slow} = '0;
    {paddr, pwdata, in_frame} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // reset value, read-only status, unmapped place
    apb(1'b0, slm_pkg::ADDR_CTRL, 32'h0);
    chk({er, rd}, {1'b0, cw(2'h0, 2'h0, 1'b0, 1'b0, 1'b0, 2'h0, slm_pkg::RST_CHEN)});
    apb(1'b1, slm_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
    chk(er, 1'b0);
    apb(1'b0, 8'h08, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    // every lane format, prompt and slow receiver
    for (int f = 0; f < 4; f++)
    begin
      cfg(cw(2'(f), slm_pkg::LCNT_8, 1'b0, 1'b0, 1'b0, slm_pkg::TEST_OFF, 2'h3));
      slow <= (f == 1);
      send(f, 20, took);
      cmp(2'(f), f, 1, 8'hFF);
    end
    slow <= 1'b0;
    // sync header kind, redundancy groups
    // enables follow the settings one edge after the write lands
    cfg(cw(slm_pkg::FMT_9B_64D, slm_pkg::LCNT_4, 1'b0, 1'b1, 1'b0, slm_pkg::TEST_OFF, 2'h3));
    repeat (2) @(posedge pclk);
    chk(sync_header_fec, 1'b1);
    chk(lane_drive_en, 8'h0F);
    cfg(cw(slm_pkg::FMT_9B_64D, slm_pkg::LCNT_4, 1'b1, 1'b0, 1'b0, slm_pkg::TEST_OFF, 2'h3));
    repeat (2) @(posedge pclk);
    chk({sync_header_fec, lane_drive_en}, {1'b0, 8'hF0});
    apb(1'b0, slm_pkg::ADDR_STATUS, 32'h0);
    chk(rd[2], 1'b1);
    // two-lane format on the alternate group
    cfg(cw(slm_pkg::FMT_9B_64Q, 2'h2, 1'b1, 1'b0, 1'b0, slm_pkg::TEST_OFF, 2'h3));
    repeat (2) @(posedge pclk);
    chk(lane_drive_en, 8'h30);
    // one pair stays on: pair 1 off zeroes channels 2 and 3, so lanes 7..4 carry zeros
    cfg(cw(slm_pkg::FMT_9B_64Q, slm_pkg::LCNT_8, 1'b1, 1'b0, 1'b0, slm_pkg::TEST_OFF, 2'h1));
    repeat (2) @(posedge pclk);
    chk(lane_drive_en, 8'hFF);
    send(7, 20, took);
    cmp(slm_pkg::FMT_9B_64Q, 7, 1, 8'h0F);
    // fill the buffer against a stalled receiver, then drain
    cfg(cw(slm_pkg::FMT_9B_8B, slm_pkg::LCNT_8, 1'b0, 1'b0, 1'b0, slm_pkg::TEST_OFF, 2'h3));
    stall <= 1'b1;
    acc = 0;
    for (int j = 0; j < 6; j++)
    begin
      send(10 + j, 4, took);
      acc += took;
    end
    chk(acc < 6, 1'b1);
    apb(1'b0, slm_pkg::ADDR_STATUS, 32'h0);
    chk(rd[3], 1'b1);
    stall <= 1'b0;
    cmp(slm_pkg::FMT_9B_8B, 10, acc, 8'hFF);
    // pin power-down, then the register power-down
    power_down_pin <= 1'b1;
    repeat (3) @(posedge pclk);
    chk({lane_drive_en, in_ready}, {8'h00, 1'b0});
    apb(1'b0, slm_pkg::ADDR_CTRL, 32'h0);
    chk(rd, ctrl_last);
    power_down_pin <= 1'b0;
    apb(1'b0, slm_pkg::ADDR_STATUS, 32'h0);
    chk(rd[1:0], 2'b10);
    cfg(cw(slm_pkg::FMT_9B_8B, slm_pkg::LCNT_8, 1'b0, 1'b0, 1'b1, slm_pkg::TEST_OFF, 2'h3));
    repeat (3) @(posedge pclk);
    chk(lane_drive_en, 8'h00);
    cfg(cw(slm_pkg::FMT_9B_8B, slm_pkg::LCNT_8, 1'b0, 1'b0, 1'b0, slm_pkg::TEST_OFF, 2'h3));
    repeat (int'(slm_pkg::FLUSH_CYC) + 4) @(posedge pclk);
    apb(1'b0, slm_pkg::ADDR_STATUS, 32'h0);
    chk(rd[1:0], 2'b00);
    slm_lane_sink_i.beats.delete();
    send(20, 20, took);
    cmp(slm_pkg::FMT_9B_8B, 20, 1, 8'hFF);
    // test patterns replace samples, lane count kept
    for (int t = 1; t < 4; t++)
    begin
      // no frames in flight while a test mode is switched in
      cfg(cw(slm_pkg::FMT_9B_8B, slm_pkg::LCNT_8, 1'b0, 1'b0, 1'b0, 2'(t), 2'h3));
      @(posedge pclk);
      slm_lane_sink_i.beats.delete();
      repeat (8) @(posedge pclk);
      chk(lane_drive_en, 8'hFF);
      // newest two beats: the oldest may still be the previous pattern
      rd = {slm_lane_sink_i.beats[$][7:0], slm_lane_sink_i.beats[$-1][7:0]};
      if (t == 1)
        chk(8'(rd[15:8] - rd[7:0]), 8'h01);
      else if (t == 2)
        chk(rd[15:8] ^ rd[7:0], 8'hFF);
      else
        chk(rd[15:0], 16'h0);
    end
    wrap_up();
  end
endmodule
